// >>> rtl/hlcr_link_regs.sv
// link capability and configuration register bank
`timescale 1ns/1ps
`default_nettype none
module hlcr_link_regs
    import hlcr_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              srst_i,
    input  wire logic              warm_rst_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [DATA_W-1:0] wdata_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    output logic      [DATA_W-1:0] rdata_o,
    input  wire logic              crc_err_lo_i,
    input  wire logic              crc_err_hi_i,
    input  wire logic              init_done_i,
    input  wire logic              proto_err_i,
    input  wire logic              ovf_err_i,
    input  wire logic              resp_err_i,
    input  wire logic              gen1_mode_i,
    input  wire logic              disconnect_i,
    input  wire logic              cfg_type0_i,
    input  wire logic [7:0]        cfg_bus_i,
    input  wire logic [DATA_W-1:0] np_base_i,
    input  wire logic [DATA_W-1:0] np_limit_i,
    output logic                   sync_flood_o,
    output logic                   bad_crc_o,
    output logic                   tx_quiet_o,
    output logic                   rx_disable_o,
    output logic                   tx_oe_o,
    output logic                   ctl_hold_o,
    output logic                   isoc_mode_o,
    output logic      [4:0]        rx_lanes_o,
    output logic      [4:0]        tx_lanes_o,
    output logic      [11:0]       rate_mhz_o,
    output logic      [UID_W-1:0]  unit_id_o,
    output logic      [39:0]       np_base_o,
    output logic      [39:0]       np_limit_o
);
    // --------------------------------------------------------------
    // state
    // --------------------------------------------------------------
    typedef struct packed {
        logic [DATA_W-1:0] rdata;
        logic [UID_W-1:0]  base_uid;
        logic              drop;
        logic              flood_en;
        logic              bad_crc;
        logic              fail;
        logic              init;
        logic              eoc;
        logic              txoff;
        logic [1:0]        crc_seen;
        logic              isoc_cfg;
        logic              isoc_act;
        logic              tri_en;
        logic              xhold;
        logic [2:0]        w_in;
        logic [2:0]        w_out;
        logic [3:0]        freq;
        logic              prot;
        logic              ovf;
        logic              pflood;
        logic              oflood;
        logic              resp;
        logic [7:0]        base_hi;
        logic [7:0]        lim_hi;
        logic [7:0]        bus;
        logic              flood;
        logic              disc;
        logic [4:0]        rx_lanes;
        logic [4:0]        tx_lanes;
        logic [11:0]       rate;
        logic [39:0]       np_base;
        logic [39:0]       np_lim;
    } hlcr_regs_t;

    hlcr_regs_t s_q;
    hlcr_regs_t s_d;

    logic w_cmd;
    logic w_ctl;
    logic w_frq;
    logic w_scr;
    logic w_mem;
    logic crc_any;
    logic flood_trig;
    logic hold_start;

    // --------------------------------------------------------------
    // decode helpers
    // --------------------------------------------------------------
    function automatic logic [4:0] lanes_of(input logic [2:0] code);
        case (code)
            WIDTH_8:  lanes_of = LANES_8;
            WIDTH_16: lanes_of = LANES_16;
            default:  lanes_of = LANES_NONE;
        endcase
    endfunction

    function automatic logic [11:0] rate_of(input logic [3:0] code);
        logic [11:0] c;
        c = {8'h00, code};
        if (code == FREQ_RES1 || code == FREQ_RES3 || code == FREQ_RESF)
            rate_of = '0;
        else if (code < FREQ_HI_LO)
            rate_of = RATE_MIN_MHZ + 12'(c * RATE_LO_STEP);
        else
            rate_of = 12'(c * RATE_HI_STEP) - RATE_MIN_MHZ;
    endfunction

    function automatic logic [DATA_W-1:0] rd_word(input logic [ADDR_W-1:0] a, input hlcr_regs_t s);
        logic [DATA_W-1:0] w;
        w = '0;
        case (a)
            OFF_CMD:
            begin
                w[7:0]                    = CAPABILITY_IDENTIFIER_VAL;
                w[CMD_NEXT_LSB +: 8]      = NEXT_CAPABILITY_POINTER_VAL;
                w[CMD_BUID_LSB +: UID_W]  = s.base_uid;
                w[CMD_UCNT_LSB +: UID_W]  = UNIT_CNT_VAL;
                w[CMD_DROP]               = s.drop;
            end
            OFF_CTL:
            begin
                w[CTL_FLOOD]              = s.flood_en;
                w[CTL_BADCRC]             = s.bad_crc;
                w[CTL_FAIL]               = s.fail;
                w[CTL_INIT]               = s.init;
                w[CTL_EOC]                = s.eoc;
                w[CTL_TXOFF]              = s.txoff;
                w[CTL_CRC_LSB +: 2]       = s.crc_seen;
                w[CTL_ISOC]               = s.isoc_cfg;
                w[CTL_3S]                 = s.tri_en;
                w[CTL_XHOLD]              = s.xhold;
                w[CTL_MWI_LSB +: 3]       = MAX_WIDTH;
                w[CTL_MWO_LSB +: 3]       = MAX_WIDTH;
                w[CTL_WI_LSB +: 3]        = s.w_in;
                w[CTL_WO_LSB +: 3]        = s.w_out;
            end
            OFF_END:  w = LINK_END_VAL;
            OFF_FRQ:
            begin
                w[4:0]                    = MINOR_REV;
                w[FRQ_MAJ_LSB +: 3]       = MAJOR_REV;
                w[FRQ_SEL_LSB +: 4]       = s.freq;
                w[FRQ_PROT]               = s.prot;
                w[FRQ_OVF]                = s.ovf;
                w[FRQ_CAP_LSB +: 16]      = RATE_CAP;
            end
            OFF_FEAT: w[7:0] = FEATURE_CAP;
            OFF_SCR:
            begin
                w[SCR_PFLOOD]             = s.pflood;
                w[SCR_OFLOOD]             = s.oflood;
                w[SCR_RESP]               = s.resp;
            end
            OFF_MEM:
            begin
                w[7:0]                    = s.base_hi;
                w[MEM_LIM_LSB +: 8]       = s.lim_hi;
                w[MEM_BUS_LSB +: 8]       = s.bus;
            end
            default:  w = '0;
        endcase
        rd_word = w;
    endfunction

    // --------------------------------------------------------------
    // next state
    // --------------------------------------------------------------
    // only writable fields are decoded; read-only bits have no write path
    assign w_cmd   = wr_i && addr_i == OFF_CMD;
    assign w_ctl   = wr_i && addr_i == OFF_CTL;
    assign w_frq   = wr_i && addr_i == OFF_FRQ;
    assign w_scr   = wr_i && addr_i == OFF_SCR;
    assign w_mem   = wr_i && addr_i == OFF_MEM;
    assign crc_any = crc_err_lo_i || crc_err_hi_i;

    // flood enables for protocol and overflow errors only act in first-generation mode
    assign flood_trig = (s_q.flood_en && crc_any)
                     || (gen1_mode_i && s_q.pflood && proto_err_i)
                     || (gen1_mode_i && s_q.oflood && ovf_err_i);
    assign hold_start = disconnect_i && !s_q.disc;

    always_comb
    begin
        s_d       = s_q;
        s_d.rdata = rd_i ? rd_word(addr_i, s_q) : '0;
        if (w_cmd)
        begin
            s_d.base_uid = wdata_i[CMD_BUID_LSB +: UID_W];
            s_d.drop     = wdata_i[CMD_DROP];
        end
        if (w_ctl)
        begin
            s_d.flood_en = wdata_i[CTL_FLOOD];
            s_d.bad_crc  = wdata_i[CTL_BADCRC];
            s_d.eoc      = s_q.eoc | wdata_i[CTL_EOC];
            s_d.txoff    = s_q.txoff | wdata_i[CTL_TXOFF];
            s_d.isoc_cfg = wdata_i[CTL_ISOC];
            s_d.tri_en   = wdata_i[CTL_3S];
            s_d.xhold    = wdata_i[CTL_XHOLD];
            s_d.w_in     = wdata_i[CTL_WI_LSB +: 3];
            s_d.w_out    = wdata_i[CTL_WO_LSB +: 3];
        end
        if (w_frq)
            s_d.freq = wdata_i[FRQ_SEL_LSB +: 4];
        if (w_scr)
        begin
            s_d.pflood = wdata_i[SCR_PFLOOD];
            s_d.oflood = wdata_i[SCR_OFLOOD];
        end
        if (w_mem)
        begin
            s_d.base_hi = wdata_i[7:0];
            s_d.lim_hi  = wdata_i[MEM_LIM_LSB +: 8];
        end
        // sticky status; write-one clears lose against a same-cycle event
        s_d.fail     = s_q.fail | crc_any;
        s_d.init     = s_q.init | init_done_i;
        s_d.crc_seen = s_q.crc_seen | {crc_err_hi_i, crc_err_lo_i};
        s_d.prot     = (s_q.prot & ~(w_frq & wdata_i[FRQ_PROT])) | proto_err_i;
        s_d.ovf      = (s_q.ovf & ~(w_frq & wdata_i[FRQ_OVF])) | ovf_err_i;
        s_d.resp     = (s_q.resp & ~(w_scr & wdata_i[SCR_RESP])) | resp_err_i;
        if (cfg_type0_i)
            s_d.bus = cfg_bus_i;
        // mode change waits for warm reset so the link never switches mid-traffic
        if (warm_rst_i)
            s_d.isoc_act = s_q.isoc_cfg;
        s_d.flood    = s_q.flood | flood_trig;
        s_d.disc     = disconnect_i;
        s_d.rx_lanes = lanes_of(s_d.w_in);
        s_d.tx_lanes = lanes_of(s_d.w_out);
        s_d.rate     = rate_of(s_d.freq);
        s_d.np_base  = {s_d.base_hi, np_base_i};
        s_d.np_lim   = {s_d.lim_hi, np_limit_i};
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            s_q          <= '0;
            s_q.rx_lanes <= LANES_8;
            s_q.tx_lanes <= LANES_8;
            s_q.rate     <= RATE_MIN_MHZ;
        end
        else
            s_q <= s_d;
    end

    // --------------------------------------------------------------
    // control hold
    // --------------------------------------------------------------
    hlcr_hold_timer u_hold (
        .clk_i      (clk_i),
        .srst_i     (srst_i),
        .start_i    (hold_start),
        .extended_i (s_q.xhold),
        .hold_o     (ctl_hold_o)
    );

    // --------------------------------------------------------------
    // outputs
    // --------------------------------------------------------------
    assign rdata_o      = s_q.rdata;
    assign sync_flood_o = s_q.flood;
    assign bad_crc_o    = s_q.bad_crc;
    assign tx_quiet_o   = s_q.txoff;
    assign rx_disable_o = s_q.txoff;
    assign tx_oe_o      = !s_q.txoff && !(disconnect_i && s_q.tri_en);
    assign isoc_mode_o  = s_q.isoc_act;
    assign rx_lanes_o   = s_q.rx_lanes;
    assign tx_lanes_o   = s_q.tx_lanes;
    assign rate_mhz_o   = s_q.rate;
    assign unit_id_o    = s_q.base_uid;
    assign np_base_o    = s_q.np_base;
    assign np_limit_o   = s_q.np_lim;

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    logic init_seen_h;
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            init_seen_h <= 1'b0;
        else
            init_seen_h <= init_seen_h | init_done_i;
    end

    sequence s_rd_ctl;
        rd_i && addr_i == OFF_CTL;
    endsequence
    sequence s_rd_frq;
        rd_i && addr_i == OFF_FRQ;
    endsequence

    property p_flood;
        s_q.flood_en && crc_any |=> sync_flood_o [*2];
    endproperty
    a_flood: assert property (p_flood) else $error("crc error did not flood");

    property p_no_flood;
        !sync_flood_o && !s_q.flood_en && !gen1_mode_i |=> !sync_flood_o;
    endproperty
    a_no_flood: assert property (p_no_flood) else $error("flood without enable");

    property p_bad_crc;
        w_ctl |=> bad_crc_o == $past(wdata_i[CTL_BADCRC]);
    endproperty
    a_bad_crc: assert property (p_bad_crc) else $error("bad crc control not applied");

    property p_fail;
        crc_any ##1 s_rd_ctl |=> rdata_o[CTL_FAIL] && rdata_o[CTL_CRC_LSB +: 2] != 2'h0;
    endproperty
    a_fail: assert property (p_fail) else $error("link failed flag not set");

    property p_init;
        s_rd_ctl and !init_seen_h |=> !rdata_o[CTL_INIT];
    endproperty
    a_init: assert property (p_init) else $error("init done without init");

    property p_txoff;
        tx_quiet_o |=> tx_quiet_o && rx_disable_o && !tx_oe_o;
    endproperty
    a_txoff: assert property (p_txoff) else $error("transmitter off not held");

    property p_crc_hi;
        crc_err_hi_i ##1 s_rd_ctl |=> rdata_o[CTL_CRC_LSB + 1];
    endproperty
    a_crc_hi: assert property (p_crc_hi) else $error("upper crc seen not set");

    property p_isoc;
        !warm_rst_i |=> $stable(isoc_mode_o);
    endproperty
    a_isoc: assert property (p_isoc) else $error("isochronous mode changed early");

    property p_width;
        s_rd_ctl |=> rdata_o[CTL_MWI_LSB +: 3] == MAX_WIDTH && rdata_o[CTL_MWO_LSB +: 3] == MAX_WIDTH;
    endproperty
    a_width: assert property (p_width) else $error("max width wrong");

    property p_rate;
        s_q.freq == 4'h5 |-> rate_mhz_o == 12'h320;
    endproperty
    a_rate: assert property (p_rate) else $error("rate decode wrong");

    property p_cap;
        s_rd_frq |=> rdata_o[FRQ_CAP_LSB +: 16] == RATE_CAP && rdata_o[FRQ_MAJ_LSB +: 3] == MAJOR_REV;
    endproperty
    a_cap: assert property (p_cap) else $error("capability or revision wrong");

    property p_resp;
        resp_err_i ##1 (rd_i && addr_i == OFF_SCR) |=> rdata_o[SCR_RESP];
    endproperty
    a_resp: assert property (p_resp) else $error("response error not reported");
endmodule // hlcr_link_regs
`default_nettype wire

// >>> rtl/hlcr_pkg.sv
// constants and types shared by the link configuration register bank
package hlcr_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int UID_W  = 5;

    // --------------------------------------------------------------
    // register offsets
    // --------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFF_CMD  = 8'hc4;
    localparam logic [ADDR_W-1:0] OFF_CTL  = 8'hc8;
    localparam logic [ADDR_W-1:0] OFF_END  = 8'hcc;
    localparam logic [ADDR_W-1:0] OFF_FRQ  = 8'hd0;
    localparam logic [ADDR_W-1:0] OFF_FEAT = 8'hd4;
    localparam logic [ADDR_W-1:0] OFF_SCR  = 8'hd8;
    localparam logic [ADDR_W-1:0] OFF_MEM  = 8'hdc;

    // --------------------------------------------------------------
    // field positions
    // --------------------------------------------------------------
    localparam int CMD_NEXT_LSB = 8;
    localparam int CMD_BUID_LSB = 16;
    localparam int CMD_UCNT_LSB = 21;
    localparam int CMD_DROP     = 28;
    localparam int CTL_FLOOD    = 1;
    localparam int CTL_BADCRC   = 3;
    localparam int CTL_FAIL     = 4;
    localparam int CTL_INIT     = 5;
    localparam int CTL_EOC      = 6;
    localparam int CTL_TXOFF    = 7;
    localparam int CTL_CRC_LSB  = 8;
    localparam int CTL_ISOC     = 12;
    localparam int CTL_3S       = 13;
    localparam int CTL_XHOLD    = 14;
    localparam int CTL_MWI_LSB  = 16;
    localparam int CTL_MWO_LSB  = 20;
    localparam int CTL_WI_LSB   = 24;
    localparam int CTL_WO_LSB   = 28;
    localparam int FRQ_MAJ_LSB  = 5;
    localparam int FRQ_SEL_LSB  = 8;
    localparam int FRQ_PROT     = 12;
    localparam int FRQ_OVF      = 13;
    localparam int FRQ_CAP_LSB  = 16;
    localparam int SCR_PFLOOD   = 16;
    localparam int SCR_OFLOOD   = 17;
    localparam int SCR_RESP     = 25;
    localparam int MEM_LIM_LSB  = 8;
    localparam int MEM_BUS_LSB  = 16;

    // --------------------------------------------------------------
    // fixed values and encodings
    // --------------------------------------------------------------
    localparam logic [7:0]        CAPABILITY_IDENTIFIER_VAL   = 8'h08;
    localparam logic [7:0]        NEXT_CAPABILITY_POINTER_VAL = 8'h54;
    localparam logic [UID_W-1:0]  UNIT_CNT_VAL = 5'h0c;
    localparam logic [2:0]        MAX_WIDTH    = 3'h1;
    localparam logic [4:0]        MINOR_REV    = 5'h00;
    localparam logic [2:0]        MAJOR_REV    = 3'h3;
    localparam logic [15:0]       RATE_CAP     = 16'h7ff5;
    localparam logic [7:0]        FEATURE_CAP  = 8'h02;
    localparam logic [DATA_W-1:0] LINK_END_VAL = 32'h0000_00d0;
    localparam logic [2:0]        WIDTH_8      = 3'h0;
    localparam logic [2:0]        WIDTH_16     = 3'h1;
    localparam logic [4:0]        LANES_8      = 5'h08;
    localparam logic [4:0]        LANES_16     = 5'h10;
    localparam logic [4:0]        LANES_NONE   = 5'h00;
    localparam logic [3:0]        FREQ_RES1    = 4'h1;
    localparam logic [3:0]        FREQ_RES3    = 4'h3;
    localparam logic [3:0]        FREQ_RESF    = 4'hf;
    localparam logic [3:0]        FREQ_HI_LO   = 4'h4;
    localparam logic [11:0]       RATE_MIN_MHZ = 12'h0c8;
    localparam logic [11:0]       RATE_LO_STEP = 12'h064;
    localparam logic [11:0]       RATE_HI_STEP = 12'h0c8;

    // --------------------------------------------------------------
    // control hold timing
    // --------------------------------------------------------------
    localparam int CLK_PERIOD_PS   = 40000;
    localparam int BIT_TIME_PS     = 2500;
    localparam int HOLD_SHORT_BITS = 16;
    localparam int HOLD_LONG_US    = 50;
    localparam int HOLD_SHORT_RAW  = (HOLD_SHORT_BITS * BIT_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int HOLD_SHORT_CYC  = (HOLD_SHORT_RAW < 1) ? 1 : HOLD_SHORT_RAW;
    localparam int HOLD_LONG_CYC   = HOLD_LONG_US * 1000000 / CLK_PERIOD_PS;
    localparam int HOLD_CNT_W      = 11;
    localparam logic [HOLD_CNT_W-1:0] HOLD_SHORT_LD = HOLD_CNT_W'(HOLD_SHORT_CYC - 1);
    localparam logic [HOLD_CNT_W-1:0] HOLD_LONG_LD  = HOLD_CNT_W'(HOLD_LONG_CYC - 1);
    localparam logic [HOLD_CNT_W-1:0] HOLD_LONG_LEN = HOLD_CNT_W'(HOLD_LONG_CYC);

    typedef enum logic {HOLD_IDLE, HOLD_RUN} hlcr_hold_st_t;
endpackage

// >>> rtl/hlcr_hold_timer.sv
// control line hold timer for the disconnect sequence
`timescale 1ns/1ps
`default_nettype none
module hlcr_hold_timer
    import hlcr_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic srst_i,
    input  wire logic start_i,
    input  wire logic extended_i,
    output logic      hold_o
);
    typedef struct packed {
        hlcr_hold_st_t           st;
        logic [HOLD_CNT_W-1:0]   cnt;
    } hlcr_tmr_t;

    hlcr_tmr_t s_q;
    hlcr_tmr_t s_d;

    always_comb
    begin
        s_d = s_q;
        case (s_q.st)
            HOLD_IDLE:
            begin
                if (start_i)
                begin
                    s_d.st  = HOLD_RUN;
                    s_d.cnt = extended_i ? HOLD_LONG_LD : HOLD_SHORT_LD;
                end
            end
            HOLD_RUN:
            begin
                if (s_q.cnt == '0)
                    s_d.st = HOLD_IDLE;
                else
                    s_d.cnt = s_q.cnt - 1'b1;
            end
            default: s_d.st = HOLD_IDLE;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            s_q <= '{st: HOLD_IDLE, cnt: '0};
        else
            s_q <= s_d;
    end

    assign hold_o = (s_q.st == HOLD_RUN);

    // helper: length of the last hold and which mode started it
    logic [HOLD_CNT_W-1:0] run_q;
    logic                  ext_q;
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            run_q <= '0;
            ext_q <= 1'b0;
        end
        else
        begin
            run_q <= hold_o ? run_q + 1'b1 : '0;
            if (start_i && s_q.st == HOLD_IDLE)
                ext_q <= extended_i;
        end
    end

    sequence s_short_start;
        start_i && !extended_i && !hold_o;
    endsequence

    property p_hold_short;
        @(posedge clk_i) disable iff (srst_i)
        s_short_start |=> hold_o ##1 !hold_o;
    endproperty
    a_hold_short: assert property (p_hold_short) else $error("short hold wrong length");

    property p_hold_long;
        @(posedge clk_i) disable iff (srst_i)
        $fell(hold_o) && ext_q |-> run_q == HOLD_LONG_LEN;
    endproperty
    a_hold_long: assert property (p_hold_long) else $error("extended hold wrong length");
endmodule // hlcr_hold_timer
`default_nettype wire

// >>> sim/hlcr_cpu_model.sv
// processor-side event source for the link register bank
`timescale 1ns/1ps
`default_nettype none
module hlcr_cpu_model (
    input  wire logic       clk_i,
    input  wire logic       go_i,
    input  wire logic [2:0] kind_i,
    output logic      [5:0] ev_o
);
    // one-cycle events: crc lo, crc hi, init, proto, ovf, resp
    initial ev_o = 6'h00;
    always @(posedge clk_i)
    begin
        ev_o <= go_i ? 6'h01 << kind_i : 6'h00;
    end
endmodule // hlcr_cpu_model
`default_nettype wire

// >>> sim/hlcr_link_regs_tb.sv
// self-checking bench for the link configuration register bank
`timescale 1ns/1ps
`default_nettype none
module hlcr_link_regs_tb;
    import hlcr_pkg::*;
    logic clk_i = 0, srst_i = 1, wr_i = 0, rd_i = 0, go = 0, dsc = 0;
    logic warm = 0, cfg0 = 0, g1 = 1;
    logic [7:0] addr_i = 8'h00, bus = 8'h00;
    logic [31:0] wdata_i = 0, base = 0, rv;
    logic [2:0] kind = 0;
    logic [5:0] ev;
    logic fl, bc, qt, rx, oe, hd, iso;
    logic [4:0] rl, tl, uid;
    logic [11:0] rate;
    logic [39:0] nb, nl;
    int n_errors = 0, checks_done = 0, cyc = 0, e;
    initial forever #20 clk_i = ~clk_i;
    hlcr_cpu_model u_hlcr_cpu_model (.clk_i(clk_i), .go_i(go), .kind_i(kind), .ev_o(ev));
    hlcr_link_regs u_hlcr_link_regs (.clk_i(clk_i), .srst_i(srst_i), .warm_rst_i(warm),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rv),
        .crc_err_lo_i(ev[0]), .crc_err_hi_i(ev[1]), .init_done_i(ev[2]), .proto_err_i(ev[3]),
        .ovf_err_i(ev[4]), .resp_err_i(ev[5]), .gen1_mode_i(g1), .disconnect_i(dsc),
        .cfg_type0_i(cfg0), .cfg_bus_i(bus), .np_base_i(base), .np_limit_i(base),
        .sync_flood_o(fl), .bad_crc_o(bc), .tx_quiet_o(qt), .rx_disable_o(rx), .tx_oe_o(oe),
        .ctl_hold_o(hd), .isoc_mode_o(iso), .rx_lanes_o(rl), .tx_lanes_o(tl),
        .rate_mhz_o(rate), .unit_id_o(uid), .np_base_o(nb), .np_limit_o(nl));
    task automatic chk(input logic [79:0] s, input logic [79:0] x);
        checks_done++;
        if (s !== x)
        begin
            n_errors++;
            $display("ERROR %0t %h %h", $time, s, x);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        {addr_i, wdata_i, wr_i} <= {a, d, 1'b1};
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] x);
        @(posedge clk_i);
        {addr_i, rd_i} <= {a, 1'b1};
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 chk(rv, x);
    endtask
    task automatic fire(input logic [2:0] k);
        @(posedge clk_i);
        {kind, go} <= {k, 1'b1};
        @(posedge clk_i);
        go <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask
    function automatic int mhz(input int f);
        return f == 0 ? 200 : f == 2 ? 400 : (f > 3 && f < 15) ? 200 * f - 200 : 0;
    endfunction
    task automatic summarize;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // a hang costs one mismatch, then the verdict
    always @(posedge clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            n_errors++;
            summarize;
        end
    end
    initial
    begin
        e = $urandom(83);
        repeat (16) @(posedge clk_i);
        srst_i <= 1'b0;
        base <= $urandom;
        rdc(OFF_CMD, 32'h0180_5408);
        rdc(OFF_CTL, 32'h0011_0000);
        rdc(OFF_END, 32'h0000_00d0);
        rdc(OFF_FEAT, 32'h0000_0002);
        rdc(OFF_FRQ, 32'h7ff5_0060);
        e = $urandom & 32'he3ff_ffff;
        wr(OFF_CMD, e);
        rdc(OFF_CMD, 32'h0180_5408 | e & 32'h001f_0000);
        chk(uid, e[20:16]);
        wr(8'he0, 32'hffff_ffff);
        rdc(8'he0, 32'h0);
        $display("fixed fields done");
        for (int f = 0; f < 16; f++)
        begin
            wr(OFF_FRQ, 32'hffff_00ff | f << 8);
            rdc(OFF_FRQ, 32'h7ff5_0060 | f << 8);
            chk(rate, mhz(f));
        end
        for (int w = 0; w < 8; w++)
        begin
            wr(OFF_CTL, w << 24 | w << 28 | 32'h0077_0000);
            rdc(OFF_CTL, w << 24 | w << 28 | 32'h0011_0000);
            chk({rl, tl}, {2{w == 0 ? 5'h08 : w == 1 ? 5'h10 : 5'h00}});
        end
        $display("rate and width done");
        fire(3'h0);
        chk(fl, 1'b0);
        rdc(OFF_CTL, 32'h7711_0110);
        wr(OFF_CTL, 32'h0000_030a);
        fire(3'h1);
        chk({fl, bc}, 2'b11);
        fire(3'h2);
        rdc(OFF_CTL, 32'h0011_033a);
        srst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        srst_i <= 1'b0;
        rdc(OFF_CTL, 32'h0011_0000);
        wr(OFF_SCR, 32'h0003_0000);
        g1 <= 1'b0;
        fire(3'h3);
        fire(3'h4);
        chk(fl, 1'b0);
        g1 <= 1'b1;
        fire(3'h4);
        chk(fl, 1'b1);
        fire(3'h3);
        fire(3'h5);
        rdc(OFF_FRQ, 32'h7ff5_3060);
        rdc(OFF_SCR, 32'h0203_0000);
        $display("error events done");
        wr(OFF_CTL, 32'h0000_1000);
        @(posedge clk_i);
        warm <= 1'b1;
        #1 chk(iso, 1'b0);
        @(posedge clk_i);
        warm <= 1'b0;
        #1 chk(iso, 1'b1);
        @(posedge clk_i);
        {cfg0, bus} <= {1'b1, base[31:24]};
        @(posedge clk_i);
        cfg0 <= 1'b0;
        wr(OFF_MEM, 32'hffff_a55a);
        rdc(OFF_MEM, {8'h00, base[31:24], 16'ha55a});
        chk({nb, nl}, {8'h5a, base, 8'ha5, base});
        wr(OFF_CTL, 32'h0000_2000);
        dsc <= 1'b1;
        @(posedge clk_i);
        #1 chk({oe, hd}, 2'b01);
        @(posedge clk_i);
        dsc <= 1'b0;
        #1 chk(hd, 1'b0);
        wr(OFF_CTL, 32'h0000_4000);
        dsc <= 1'b1;
        repeat (1250) @(posedge clk_i);
        #1 chk(hd, 1'b1);
        @(posedge clk_i);
        dsc <= 1'b0;
        #1 chk({oe, hd}, 2'b10);
        wr(OFF_CTL, 32'h0000_0080);
        wr(OFF_CTL, 32'h0000_0000);
        #41 chk({oe, qt, rx}, 3'b011);
        rdc(OFF_CTL, 32'h0011_0080);
        $display("link off done");
        summarize;
    end
endmodule // hlcr_link_regs_tb
`default_nettype wire
